// file: design/codec_control_regs.sv
// Three-wire serial register bank and control decode for the mono codec
module codec_control_regs (
    input wire logic clk,
    input wire logic rstn,
    input wire logic chip_power_down_n,
    input wire logic ctl_cs_n,
    input wire logic ctl_sclk,
    input wire logic ctl_data_in,
    output logic ctl_data_out,
    output logic ctl_data_oe,
    input wire logic sample_tick,
    output logic adc_power_on,
    output logic adc_data_valid,
    output logic dac_power_on,
    output logic line_out_power_on,
    output logic speaker_power_on,
    output logic beep_input_power_on,
    output logic common_voltage_power_on,
    output logic prog_filter_power_on,
    output logic pll_power_on,
    output logic all_blocks_down,
    output logic pll_clock_mode,
    output logic master_mode,
    output logic master_clock_out,
    output logic mic_supply_on,
    output logic [2:0] mic_gain,
    output logic dac_to_line_active,
    output logic beep_to_line_active,
    output logic line_output_grounded,
    output logic line_out_power_save,
    output logic dac_to_speaker_active,
    output logic beep_to_speaker_active,
    output logic speaker_pos_hiz,
    output logic speaker_neg_mid,
    output logic [1:0] speaker_gain_select,
    output logic filter_source_select,
    output logic dac_source_select,
    output logic serial_out_source_select,
    output logic [3:0] pll_reference_select,
    output logic [1:0] bit_clock_rate_select,
    output logic [1:0] audio_format_select,
    output logic [7:0] rate_and_clock_control,
    output logic [5:0] level_control_timers,
    output logic record_level_ctrl_enable,
    output logic playback_level_ctrl_enable,
    output logic limiter_zero_cross_enable,
    output logic [1:0] limiter_atten_step,
    output logic [1:0] limiter_threshold,
    output logic [1:0] recovery_gain_step,
    output logic [7:0] record_reference_level,
    output logic [5:0] playback_reference_level,
    output logic [7:0] input_volume_level,
    output logic [7:0] output_volume_level
);
    typedef enum logic [1:0] {st_idle, st_shift, st_read, st_skip} ser_state_t;

    // Combined reset: the power-down pin clears the bank like rstn
    logic pdn_s1_reg, pdn_s2_reg, pdn_s3_reg, pdn_reg;
    logic cs_s1_reg, cs_s2_reg, cs_s3_reg, cs_reg;
    logic sck_s1_reg, sck_s2_reg, sck_s3_reg, sck_reg;
    logic din_s1_reg, din_s2_reg, din_s3_reg, din_reg;
    logic tick_s1_reg, tick_s2_reg, tick_s3_reg, tick_reg;

    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            {pdn_s1_reg, pdn_s2_reg, pdn_s3_reg, pdn_reg} <= 4'h0;
            {cs_s1_reg, cs_s2_reg, cs_s3_reg, cs_reg} <= 4'hf;
            {sck_s1_reg, sck_s2_reg, sck_s3_reg, sck_reg} <= 4'h0;
            {din_s1_reg, din_s2_reg, din_s3_reg, din_reg} <= 4'h0;
            {tick_s1_reg, tick_s2_reg, tick_s3_reg, tick_reg} <= 4'h0;
        end else begin
            {pdn_s1_reg, pdn_s2_reg, pdn_s3_reg} <=
                {chip_power_down_n, pdn_s1_reg, pdn_s2_reg};
            {cs_s1_reg, cs_s2_reg, cs_s3_reg} <=
                {ctl_cs_n, cs_s1_reg, cs_s2_reg};
            {sck_s1_reg, sck_s2_reg, sck_s3_reg} <=
                {ctl_sclk, sck_s1_reg, sck_s2_reg};
            {din_s1_reg, din_s2_reg, din_s3_reg} <=
                {ctl_data_in, din_s1_reg, din_s2_reg};
            {tick_s1_reg, tick_s2_reg, tick_s3_reg} <=
                {sample_tick, tick_s1_reg, tick_s2_reg};
            // A change counts once stages two and three agree
            if (pdn_s2_reg == pdn_s3_reg) pdn_reg <= pdn_s3_reg;
            if (cs_s2_reg == cs_s3_reg) cs_reg <= cs_s3_reg;
            if (sck_s2_reg == sck_s3_reg) sck_reg <= sck_s3_reg;
            if (din_s2_reg == din_s3_reg) din_reg <= din_s3_reg;
            if (tick_s2_reg == tick_s3_reg) tick_reg <= tick_s3_reg;
        end
    end

    // Bank reset is taken synchronously so a pin glitch cannot half-clear it
    wire bank_clear = !pdn_reg; // RULE_23

    logic sck_d_reg, cs_d_reg, tick_d_reg;
    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            sck_d_reg <= 1'b0;
            cs_d_reg <= 1'b1;
            tick_d_reg <= 1'b0;
        end else begin
            sck_d_reg <= sck_reg;
            cs_d_reg <= cs_reg;
            tick_d_reg <= tick_reg;
        end
    end
    wire sck_rise = sck_reg && !sck_d_reg;
    wire sck_fall = !sck_reg && sck_d_reg;
    wire cs_fall = !cs_reg && cs_d_reg;
    wire cs_rise = cs_reg && !cs_d_reg;
    wire fs_tick = tick_reg && !tick_d_reg;

    // Serial control port
    ser_state_t state_reg, state_next;
    logic [15:0] shift_reg;
    logic [4:0] count_reg;
    logic [7:0] rdata_reg;
    logic oe_reg;
    logic frame_ok_reg;

    wire [15:0] shift_next = {shift_reg[14:0], din_reg};
    wire [4:0] count_next = count_reg + 5'h01;
    wire header_done = sck_rise && (count_next == codec_regs_pkg::bits_header);
    wire header_chip_ok = (shift_next[7:6] == codec_regs_pkg::chip_addr);
    wire header_read = shift_next[5];
    wire [4:0] header_addr = shift_next[4:0];
    wire data_done = (count_reg == codec_regs_pkg::bits_frame);
    wire [4:0] wr_addr = shift_reg[12:8];
    wire [7:0] wr_data = shift_reg[7:0];
    // Write commits only on the rising edge of chip select
    wire wr_commit = cs_rise && frame_ok_reg && data_done; // RULE_26
    wire in_range = (wr_addr < 5'(codec_regs_pkg::num_regs));

    always_comb begin
        state_next = state_reg;
        unique case (state_reg)
            st_idle: if (cs_fall) state_next = st_shift;
            st_shift: begin
                if (cs_rise) state_next = st_idle;
                else if (header_done && !header_chip_ok) state_next = st_skip;
                else if (header_done && header_read) state_next = st_read;
            end
            st_read: if (cs_rise) state_next = st_idle;
            st_skip: if (cs_rise) state_next = st_idle;
        endcase
    end

    logic [7:0] regs_reg [codec_regs_pkg::num_regs];
    logic [7:0] rd_word;
    always_comb begin
        rd_word = 8'h00;
        if (header_addr < 5'(codec_regs_pkg::num_regs)) begin
            rd_word = regs_reg[header_addr[3:0]];
        end
    end

    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            state_reg <= st_idle;
            shift_reg <= 16'h0000;
            count_reg <= 5'h00;
            rdata_reg <= 8'h00;
            oe_reg <= 1'b0;
            frame_ok_reg <= 1'b0;
        end else begin
            state_reg <= state_next;
            if (cs_fall) begin
                count_reg <= 5'h00;
                frame_ok_reg <= 1'b0;
            end else if (sck_rise && state_reg == st_shift) begin
                shift_reg <= shift_next;
                count_reg <= count_next;
                if (header_done) frame_ok_reg <= header_chip_ok && !header_read;
            end
            // Read data leaves on falling clock edges after the header
            if (header_done && header_chip_ok && header_read) begin
                rdata_reg <= rd_word;
            end else if (sck_fall && state_reg == st_read && oe_reg) begin
                rdata_reg <= {rdata_reg[6:0], 1'b0};
            end
            if (cs_rise || state_reg != st_read) oe_reg <= 1'b0;
            else if (sck_fall) oe_reg <= 1'b1;
        end
    end
    assign ctl_data_out = oe_reg ? rdata_reg[7] : 1'b0; // RULE_25
    assign ctl_data_oe = oe_reg;

    // Register bank, reset values and writable masks per entry
    localparam logic [7:0] rst_tab [codec_regs_pkg::num_regs] = '{
        codec_regs_pkg::rst_power_one, codec_regs_pkg::rst_power_two,
        codec_regs_pkg::rst_route_one, codec_regs_pkg::rst_route_two,
        codec_regs_pkg::rst_format, codec_regs_pkg::rst_rate,
        codec_regs_pkg::rst_timers, codec_regs_pkg::rst_alc_one,
        codec_regs_pkg::rst_rec_ref, codec_regs_pkg::rst_in_vol,
        codec_regs_pkg::rst_out_vol, codec_regs_pkg::rst_alc_three};
    localparam logic [7:0] mask_tab [codec_regs_pkg::num_regs] = '{
        codec_regs_pkg::mask_power_one, codec_regs_pkg::mask_power_two,
        codec_regs_pkg::mask_route_one, codec_regs_pkg::mask_full,
        codec_regs_pkg::mask_full, codec_regs_pkg::mask_full,
        codec_regs_pkg::mask_timers, codec_regs_pkg::mask_alc_one,
        codec_regs_pkg::mask_full, codec_regs_pkg::mask_full,
        codec_regs_pkg::mask_full, codec_regs_pkg::mask_full};

    genvar gi;
    generate
        for (gi = 0; gi < codec_regs_pkg::num_regs; gi++) begin : g_reg
            wire hit = wr_commit && in_range && (wr_addr == 5'(gi));
            always_ff @(posedge clk or negedge rstn) begin
                if (!rstn) begin
                    regs_reg[gi] <= rst_tab[gi];
                end else if (bank_clear) begin
                    regs_reg[gi] <= rst_tab[gi]; // RULE_23
                end else if (hit) begin
                    // Undefined bits are forced to zero
                    regs_reg[gi] <= wr_data & mask_tab[gi]; // RULE_24
                end
            end
        end
    endgenerate

    wire [7:0] r_pw1 = regs_reg[codec_regs_pkg::addr_power_one[3:0]];
    wire [7:0] r_pw2 = regs_reg[codec_regs_pkg::addr_power_two[3:0]];
    wire [7:0] r_rt1 = regs_reg[codec_regs_pkg::addr_route_one[3:0]];
    wire [7:0] r_rt2 = regs_reg[codec_regs_pkg::addr_route_two[3:0]];
    wire [7:0] r_fmt = regs_reg[codec_regs_pkg::addr_format[3:0]];
    wire [7:0] r_rate = regs_reg[codec_regs_pkg::addr_rate[3:0]];
    wire [7:0] r_tim = regs_reg[codec_regs_pkg::addr_timers[3:0]];
    wire [7:0] r_al1 = regs_reg[codec_regs_pkg::addr_alc_one[3:0]];
    wire [7:0] r_al3 = regs_reg[codec_regs_pkg::addr_alc_three[3:0]];

    // Global power-down; register contents are left alone
    wire all_down = (r_pw1 == 8'h00) && !r_pw2[codec_regs_pkg::b_pll_pwr]
        && !r_pw2[codec_regs_pkg::b_mck_en]; // RULE_04
    wire chip_up = pdn_reg && !all_down; // RULE_03

    wire adc_on = chip_up && r_pw1[codec_regs_pkg::b_adc_pwr]; // RULE_03
    wire lo_on = chip_up && r_pw1[codec_regs_pkg::b_lo_pwr];
    wire spk_on = chip_up && r_pw1[codec_regs_pkg::b_spk_pwr];

    // ADC initialisation counter in sample periods
    logic adc_on_d_reg;
    logic [10:0] init_cnt_reg;
    logic adc_valid_reg;
    wire [10:0] init_len = r_rate[codec_regs_pkg::b_adc_init] ?
        codec_regs_pkg::adc_init_short : codec_regs_pkg::adc_init_long;
    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            adc_on_d_reg <= 1'b0;
            init_cnt_reg <= 11'h000;
            adc_valid_reg <= 1'b0;
        end else begin
            adc_on_d_reg <= adc_on;
            if (!adc_on) begin
                init_cnt_reg <= 11'h000;
                adc_valid_reg <= 1'b0;
            end else if (!adc_on_d_reg) begin
                init_cnt_reg <= init_len; // RULE_01
                adc_valid_reg <= 1'b0;
            end else if (fs_tick && init_cnt_reg != 11'h000) begin
                init_cnt_reg <= init_cnt_reg - 11'h001;
                adc_valid_reg <= (init_cnt_reg == 11'h001); // RULE_01
            end
        end
    end
    assign adc_data_valid = adc_valid_reg;

    // Master clock output: 256 system periods per output period here
    // is a stand-in; the real ratio is set by the analogue clock tree.
    logic [7:0] mck_cnt_reg;
    logic mck_reg;
    wire mck_en = chip_up && r_pw2[codec_regs_pkg::b_mck_en];
    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            mck_cnt_reg <= 8'h00;
            mck_reg <= 1'b0;
        end else if (!mck_en) begin
            mck_cnt_reg <= 8'h00;
            mck_reg <= 1'b0; // RULE_09
        end else if (mck_cnt_reg == codec_regs_pkg::mclk_half) begin
            mck_cnt_reg <= 8'h00;
            mck_reg <= !mck_reg; // RULE_09
        end else begin
            mck_cnt_reg <= mck_cnt_reg + 8'h01;
        end
    end
    assign master_clock_out = mck_reg;

    assign adc_power_on = adc_on;
    assign dac_power_on = chip_up && r_pw1[codec_regs_pkg::b_dac_pwr];
    assign line_out_power_on = lo_on;
    assign speaker_power_on = spk_on;
    assign beep_input_power_on = chip_up && r_pw1[codec_regs_pkg::b_beep_pwr];
    // Host is trusted to keep this set while anything runs
    assign common_voltage_power_on =
        chip_up && r_pw1[codec_regs_pkg::b_vcm_pwr]; // RULE_05
    assign prog_filter_power_on = chip_up && r_pw1[codec_regs_pkg::b_filt_pwr];
    assign pll_power_on = chip_up && r_pw2[codec_regs_pkg::b_pll_pwr];
    assign all_blocks_down = !chip_up;
    assign pll_clock_mode = r_pw2[codec_regs_pkg::b_pll_pwr]; // RULE_08
    assign master_mode = r_pw2[codec_regs_pkg::b_master];

    assign mic_supply_on = adc_on && r_rt1[codec_regs_pkg::b_mic_sup]; // RULE_12
    assign mic_gain = {r_rt1[codec_regs_pkg::b_mic_gain_bit2],
        r_rt2[codec_regs_pkg::b_mic_gain_bit1], r_rt1[codec_regs_pkg::b_mic_gain_bit0]}; // RULE_11
    assign dac_to_line_active = lo_on && r_rt1[codec_regs_pkg::b_dac_lo]; // RULE_13
    // Beep paths ignore the beep power bit on purpose
    assign beep_to_line_active = lo_on && r_rt2[codec_regs_pkg::b_beep_lo]; // RULE_18 RULE_06
    assign line_output_grounded = !lo_on; // RULE_13
    assign line_out_power_save = r_rt2[codec_regs_pkg::b_lo_ps]; // RULE_19
    assign dac_to_speaker_active = r_rt1[codec_regs_pkg::b_dac_spk]; // RULE_14
    assign beep_to_speaker_active = r_rt1[codec_regs_pkg::b_beep_spk]; // RULE_14 RULE_06
    wire spk_save = spk_on && !r_rt1[codec_regs_pkg::b_spk_psn];
    assign speaker_pos_hiz = !spk_on || spk_save; // RULE_15
    assign speaker_neg_mid = spk_save; // RULE_15
    assign speaker_gain_select = r_rt2[codec_regs_pkg::b_spk_gain +: 2];
    assign filter_source_select = r_rt2[codec_regs_pkg::b_filt_src]; // RULE_16
    assign dac_source_select = r_rt2[codec_regs_pkg::b_dac_src]; // RULE_16
    assign serial_out_source_select = r_rt2[codec_regs_pkg::b_sdo_src]; // RULE_17

    assign pll_reference_select = r_fmt[codec_regs_pkg::b_pll_ref +: 4]; // RULE_20
    assign bit_clock_rate_select = r_fmt[codec_regs_pkg::b_bck_rate +: 2]; // RULE_20
    assign audio_format_select = r_fmt[codec_regs_pkg::b_fmt +: 2]; // RULE_20
    assign rate_and_clock_control = r_rate;
    assign level_control_timers = r_tim[5:0];

    // Clocks must run while ALCs are enabled; that is the host's duty
    assign record_level_ctrl_enable = r_al1[codec_regs_pkg::b_rec_alc]; // RULE_21 RULE_07
    assign playback_level_ctrl_enable = r_al1[codec_regs_pkg::b_play_alc]; // RULE_21
    assign limiter_zero_cross_enable = !r_al1[codec_regs_pkg::b_zc_dis]; // RULE_21
    assign limiter_atten_step = r_al1[codec_regs_pkg::b_lmat +: 2];
    assign limiter_threshold = {r_al3[codec_regs_pkg::b_lmth1],
        r_al1[codec_regs_pkg::b_lmth0]}; // RULE_02
    assign recovery_gain_step = {r_al3[codec_regs_pkg::b_rgain1],
        r_al1[codec_regs_pkg::b_rgain0]}; // RULE_02
    assign record_reference_level =
        regs_reg[codec_regs_pkg::addr_rec_ref[3:0]]; // RULE_10
    assign playback_reference_level = r_al3[codec_regs_pkg::b_oref +: 6]; // RULE_10
    assign input_volume_level = regs_reg[codec_regs_pkg::addr_in_vol[3:0]]; // RULE_22
    assign output_volume_level = regs_reg[codec_regs_pkg::addr_out_vol[3:0]]; // RULE_22
endmodule : codec_control_regs

// file: include/codec_regs_pkg.sv
// Register map, field positions, reset values and timing for the codec control bank
// Overview of operation
// RULE_01: ADC data held off for init period
// RULE_02: Threshold and recovery step split into 0BH
// RULE_03: Block bit or power-down pin stops block
// RULE_04: All power bits clear powers everything down
// RULE_05: Host keeps common voltage on when needed
// RULE_06: Beep paths follow switches, not beep power
// RULE_07: Host supplies clocks while converters run
// RULE_08: PLL power bit selects clock source
// RULE_09: Clock output low or 256fs when enabled
// RULE_10: Playback reference 28H, record reference C5H
// RULE_11: Mic gain three bits across two registers
// RULE_12: Mic supply needs ADC powered
// RULE_13: DAC line switch needs line power
// RULE_14: DAC and beep feed speaker via switches
// RULE_15: Speaker power save: positive hi-z, negative mid
// RULE_16: Filter and DAC input source selects
// RULE_17: Serial output source select
// RULE_18: Beep line switch needs line power
// RULE_19: Line output power save bit
// RULE_20: Mode register one fields and defaults
// RULE_21: ALC enables, zero-cross disable inverted
// RULE_22: Volumes reset to 91H
// RULE_23: Power-down pin resets every register
// RULE_24: Host writes zero to undefined bits
// RULE_25: Registers via three-wire serial port
// RULE_26: Fields update on completed write
package codec_regs_pkg;
    localparam logic [4:0] addr_power_one = 5'h00;
    localparam logic [4:0] addr_power_two = 5'h01;
    localparam logic [4:0] addr_route_one = 5'h02;
    localparam logic [4:0] addr_route_two = 5'h03;
    localparam logic [4:0] addr_format = 5'h04;
    localparam logic [4:0] addr_rate = 5'h05;
    localparam logic [4:0] addr_timers = 5'h06;
    localparam logic [4:0] addr_alc_one = 5'h07;
    localparam logic [4:0] addr_rec_ref = 5'h08;
    localparam logic [4:0] addr_in_vol = 5'h09;
    localparam logic [4:0] addr_out_vol = 5'h0a;
    localparam logic [4:0] addr_alc_three = 5'h0b;
    localparam int num_regs = 12;
    // Reset values
    localparam logic [7:0] rst_power_one = 8'h00;
    localparam logic [7:0] rst_power_two = 8'h00;
    localparam logic [7:0] rst_route_one = 8'h01;
    localparam logic [7:0] rst_route_two = 8'h81;
    localparam logic [7:0] rst_format = 8'h02;
    localparam logic [7:0] rst_rate = 8'h00;
    localparam logic [7:0] rst_timers = 8'h00;
    localparam logic [7:0] rst_alc_one = 8'h01;
    localparam logic [7:0] rst_rec_ref = 8'hc5;
    localparam logic [7:0] rst_in_vol = 8'h91;
    localparam logic [7:0] rst_out_vol = 8'h91;
    localparam logic [7:0] rst_alc_three = 8'h28;
    // Writable bit masks; undefined bits stay zero
    localparam logic [7:0] mask_power_one = 8'hfd;
    localparam logic [7:0] mask_power_two = 8'h0b;
    localparam logic [7:0] mask_route_one = 8'hf7;
    localparam logic [7:0] mask_timers = 8'h3f;
    localparam logic [7:0] mask_alc_one = 8'h7f;
    localparam logic [7:0] mask_full = 8'hff;
    // Field positions: power_control_one
    localparam int b_adc_pwr = 0;
    localparam int b_dac_pwr = 2;
    localparam int b_lo_pwr = 3;
    localparam int b_spk_pwr = 4;
    localparam int b_beep_pwr = 5;
    localparam int b_vcm_pwr = 6;
    localparam int b_filt_pwr = 7;
    // power_control_two
    localparam int b_pll_pwr = 0;
    localparam int b_mck_en = 1;
    localparam int b_master = 3;
    // routing_select_one
    localparam int b_mic_gain_bit0 = 0;
    localparam int b_mic_gain_bit2 = 1;
    localparam int b_mic_sup = 2;
    localparam int b_dac_lo = 4;
    localparam int b_dac_spk = 5;
    localparam int b_beep_spk = 6;
    localparam int b_spk_psn = 7;
    // routing_select_two
    localparam int b_filt_src = 0;
    localparam int b_dac_src = 1;
    localparam int b_beep_lo = 2;
    localparam int b_spk_gain = 3;
    localparam int b_mic_gain_bit1 = 5;
    localparam int b_lo_ps = 6;
    localparam int b_sdo_src = 7;
    // format_and_pll_control
    localparam int b_fmt = 0;
    localparam int b_bck_rate = 2;
    localparam int b_pll_ref = 4;
    // rate_and_clock_control
    localparam int b_adc_init = 7;
    // level_control_mode_one
    localparam int b_lmth0 = 0;
    localparam int b_rgain0 = 1;
    localparam int b_lmat = 2;
    localparam int b_zc_dis = 4;
    localparam int b_rec_alc = 5;
    localparam int b_play_alc = 6;
    // level_control_mode_three
    localparam int b_oref = 0;
    localparam int b_lmth1 = 6;
    localparam int b_rgain1 = 7;
    // Serial frame: 2-bit chip address, r/w, 5-bit address, 8-bit data
    localparam logic [1:0] chip_addr = 2'h2;
    localparam logic [4:0] bits_header = 5'h08;
    localparam logic [4:0] bits_frame = 5'h10;
    // ADC initialisation, in sample periods
    localparam logic [10:0] adc_init_long = 11'h423;
    localparam logic [10:0] adc_init_short = 11'h123;
    // Master clock output period is 256 system clock periods
    localparam int mclk_ratio = 256;
    localparam logic [7:0] mclk_half = 8'(mclk_ratio / 2 - 1);
endpackage : codec_regs_pkg

// file: testbench/codec_control_regs_assertions.sv
// Port assertions for the codec control bank
module ctl_checks (
    input clk,
    input rstn,
    input chip_power_down_n,
    input ctl_cs_n,
    input ctl_data_oe,
    input adc_power_on,
    input adc_data_valid,
    input line_out_power_on,
    input speaker_power_on,
    input pll_power_on,
    input all_blocks_down,
    input pll_clock_mode,
    input master_clock_out,
    input mic_supply_on,
    input dac_to_line_active,
    input beep_to_line_active,
    input speaker_pos_hiz,
    input speaker_neg_mid,
    input [7:0] output_volume_level
);
    default clocking @(posedge clk);
    endclocking
    default disable iff (!rstn);
    chk_pll_source: assert property (pll_clock_mode == pll_power_on)
        else $error("pll mode");
    chk_mic_gate: assert property (mic_supply_on |-> adc_power_on)
        else $error("mic gate");
    chk_line_gate: assert property (
        (dac_to_line_active || beep_to_line_active) |-> line_out_power_on)
        else $error("line gate");
    chk_spk_save: assert property (
        speaker_neg_mid |-> speaker_pos_hiz && speaker_power_on)
        else $error("speaker save");
    chk_mclk_idle: assert property (
        all_blocks_down [*3] |-> !master_clock_out)
        else $error("clock out idle");
    chk_adc_hold: assert property (
        $rose(adc_power_on) |=> !adc_data_valid [*8])
        else $error("adc early");
    chk_oe_release: assert property (
        ctl_cs_n [*8] |-> !ctl_data_oe)
        else $error("oe release");
    chk_pdn_clear: assert property (
        !chip_power_down_n [*8] |-> all_blocks_down
        && output_volume_level == 8'h91)
        else $error("pdn clear");
endmodule : ctl_checks
bind codec_control_regs ctl_checks chk_u (.*);

// file: testbench/codec_control_regs_tb.sv
// Random and corner-case bench for the codec control bank
module codec_control_regs_tb;
    timeunit 1ns;
    timeprecision 1ns;
    logic clk, rstn, chip_power_down_n, ctl_cs_n, ctl_sclk, ctl_data_in;
    logic sample_tick, host_data, ctl_data_out, ctl_data_oe;
    logic adc_power_on, adc_data_valid, dac_power_on, line_out_power_on;
    logic speaker_power_on, beep_input_power_on, common_voltage_power_on;
    logic prog_filter_power_on, pll_power_on, all_blocks_down, master_mode;
    logic pll_clock_mode, master_clock_out, mic_supply_on, line_out_power_save;
    logic dac_to_line_active, beep_to_line_active, line_output_grounded;
    logic dac_to_speaker_active, beep_to_speaker_active, speaker_pos_hiz;
    logic speaker_neg_mid, filter_source_select, dac_source_select;
    logic serial_out_source_select, limiter_zero_cross_enable;
    logic record_level_ctrl_enable, playback_level_ctrl_enable;
    logic [2:0] mic_gain;
    logic [3:0] pll_reference_select;
    logic [1:0] speaker_gain_select, bit_clock_rate_select, audio_format_select;
    logic [1:0] limiter_atten_step, limiter_threshold, recovery_gain_step;
    logic [5:0] level_control_timers, playback_reference_level;
    logic [7:0] rate_and_clock_control, record_reference_level;
    logic [7:0] input_volume_level, output_volume_level, rd, v;
    logic [7:0] exp_q [13];
    logic [7:0] rst_tab [13] = '{8'h00, 8'h00, 8'h01, 8'h81, 8'h02, 8'h00,
        8'h00, 8'h01, 8'hc5, 8'h91, 8'h91, 8'h28, 8'h00};
    // Slot 0ch reads zero
    logic [7:0] msk_tab [13] = '{8'hfd, 8'h0b, 8'hf7, 8'hff, 8'hff, 8'hff,
        8'h3f, 8'h7f, 8'hff, 8'hff, 8'hff, 8'hff, 8'h00};
    int err_total = 0, n_tests = 0, seed = 33, n;
    assign ctl_data_in = ctl_data_oe ? ctl_data_out : host_data;
    codec_control_regs dut_u (.*);
    ctl_host host_u (.ctl_wire(ctl_data_in), .*);
    function automatic logic [7:0] reg_exp(input int a, input logic [7:0] d);
        return d & msk_tab[a];
    endfunction : reg_exp
    task automatic wr(input logic [4:0] a, input logic [7:0] d);
        host_u.xfer(2'h2, 1'b0, a, d, rd);
    endtask : wr
    task automatic check(input string what, input logic [15:0] seen, exp);
        n_tests++;
        if (seen !== exp) begin
            err_total++;
            $display("[ERR] %s expected %h seen %h", what, exp, seen);
        end
    endtask : check
    task automatic end_of_test;
        $display("comparisons %0d mismatches %0d", n_tests, err_total);
        if (err_total == 0 && n_tests > 0) $display("SIMULATION PASSED");
        else $display("SIMULATION FAILED");
        $finish;
    endtask : end_of_test
    initial begin
        clk = 1'b0;
        forever #10 clk = ~clk;
    end
    initial begin
        rstn = 1'b0;
        chip_power_down_n = 1'b1;
        sample_tick = 1'b0;
        repeat (3) @(posedge clk);
        rstn <= 1'b1;
        repeat (10) @(posedge clk);
        check("defaults", {mic_gain, limiter_threshold, filter_source_select,
            dac_source_select, serial_out_source_select, audio_format_select,
            limiter_zero_cross_enable, line_out_power_save}, 16'h02da);
        for (int a = 0; a < 13; a++) begin
            host_u.xfer(2'h2, 1'b1, 5'(a), 8'h00, rd);
            check("reset", rd, rst_tab[a]);
            v = (a == 12) ? 8'h5a : reg_exp(a, 8'($random(seed)));
            if (a == 0) v[6] = |v;
            wr(5'(a), v);
            exp_q[a] = reg_exp(a, v);
        end
        $display("reset done");
        // Foreign chip address must not land
        host_u.xfer(2'h1, 1'b0, 5'h09, ~exp_q[9], rd);
        for (int a = 0; a < 13; a++) begin
            host_u.xfer(2'h2, 1'b1, 5'(a), 8'h00, rd);
            check("readback", rd, exp_q[a]);
        end
        check("mic gain", mic_gain, {exp_q[2][1], exp_q[3][5], exp_q[2][0]});
        check("split", {limiter_threshold, recovery_gain_step}, {exp_q[11][6],
            exp_q[7][0], exp_q[11][7], exp_q[7][1]});
        $display("random done");
        for (int k = 0; k < 2; k++) begin
            wr(5'h00, 8'h40);
            wr(5'h05, k ? 8'h80 : 8'h00);
            wr(5'h00, 8'h41);
            n = 0;
            // Tick held 4 clk so the input filter passes it
            while (adc_data_valid !== 1'b1 && n < 1100) begin
                sample_tick <= 1'b1;
                repeat (4) @(posedge clk);
                sample_tick <= 1'b0;
                repeat (4) @(posedge clk);
                n++;
            end
            check("adc init", 16'(n), k ? 16'd291 : 16'd1059);
        end
        $display("adc done");
        wr(5'h01, 8'h00);
        wr(5'h00, 8'h00);
        check("all down", {all_blocks_down, master_clock_out, dac_power_on},
            3'h4);
        host_u.xfer(2'h2, 1'b1, 5'h03, 8'h00, rd);
        check("kept", rd, exp_q[3]);
        chip_power_down_n <= 1'b0;
        repeat (10) @(posedge clk);
        chip_power_down_n <= 1'b1;
        host_u.xfer(2'h2, 1'b1, 5'h0a, 8'h00, rd);
        check("pdn volume", rd, 8'h91);
        $display("power done");
        wr(5'h02, 8'h50);
        wr(5'h03, 8'h85);
        for (int k = 0; k < 2; k++) begin
            wr(5'h00, k ? 8'h48 : 8'h40);
            check("paths", {dac_to_line_active, beep_to_line_active,
                beep_to_speaker_active, line_output_grounded},
                k ? 4'he : 4'h3);
        end
        $display("routing done");
        end_of_test();
    end
    // Run is about 26k cycles
    initial begin
        repeat (100000) @(posedge clk);
        err_total++;
        end_of_test();
    end
endmodule : codec_control_regs_tb

// file: testbench/ctl_host.sv
// Host model driving the three-wire control port
module ctl_host (
    input clk,
    input ctl_wire,
    output logic ctl_cs_n,
    output logic ctl_sclk,
    output logic host_data
);
    timeunit 1ns;
    timeprecision 1ns;
    initial begin
        ctl_cs_n = 1'b1;
        ctl_sclk = 1'b1;
        host_data = 1'b0;
    end
    // 8-clk halves outlast the input filter
    task automatic xfer(input logic [1:0] chip, logic rw,
            logic [4:0] addr, logic [7:0] wd, output logic [7:0] rdata);
        logic [15:0] frame;
        frame = {chip, rw, addr, wd};
        @(posedge clk);
        ctl_cs_n <= 1'b0;
        for (int i = 15; i >= 0; i--) begin
            repeat (8) @(posedge clk);
            ctl_sclk <= 1'b0;
            // Toggle so a stale bit never reads back
            host_data <= (rw && i < 8) ? ~host_data : frame[i];
            repeat (8) @(posedge clk);
            ctl_sclk <= 1'b1;
            if (i < 8) rdata[i] = ctl_wire;
        end
        repeat (8) @(posedge clk);
        ctl_cs_n <= 1'b1;
        repeat (12) @(posedge clk);
    endtask : xfer
endmodule : ctl_host
